//--- mdc_consts.vh
// register offsets, field positions and mode and size codes of the dma controller
// included by mdc_top.v, the port checker and the bench
`ifndef MDC_CONSTS_VH
`define MDC_CONSTS_VH
`define MDC_REG_CFG 8'h00
`define MDC_REG_CTLBASE 8'h04
`define MDC_REG_ENA_SET 8'h08
`define MDC_REG_ENA_CLR 8'h0C
`define MDC_REG_ATTR_SET 8'h10
`define MDC_REG_ATTR_CLR 8'h14
`define MDC_REG_ATTR 8'h18
`define MDC_REG_PRIO 8'h1C
`define MDC_REG_SWREQ 8'h20
`define MDC_REG_MASK 8'h24
`define MDC_REG_ERR 8'h28
`define MDC_REG_CHSEL 8'h2C
`define MDC_REG_SIZE 8'h30
`define MDC_REG_MODE 8'h34
`define MDC_REG_DONE 8'h38
`define MDC_REG_STATUS 8'h3C
`define MDC_CFG_EN 0
`define MDC_BASE_ALIGN 10
`define MDC_DESC_BYTES 16
`define MDC_ALT_INDEX 32
`define MDC_MODE_STOP 3'h0
`define MDC_MODE_BASIC 3'h1
`define MDC_MODE_AUTO 3'h2
`define MDC_MODE_PING 3'h3
`define MDC_MODE_MSG 3'h4
`define MDC_MODE_PSG 3'h6
`define MDC_SIZE_BYTE 2'h0
`define MDC_SIZE_HALF 2'h1
`define MDC_SIZE_WORD 2'h2
`define MDC_INC_NONE 2'h3
`define MDC_CW_MODE 0
`define MDC_CW_NM1 4
`define MDC_CW_ARB 14
`define MDC_CW_SSIZE 24
`define MDC_CW_SINC 26
`define MDC_CW_DSIZE 28
`define MDC_CW_DINC 30
`endif

//--- mdc_top.v
// multichannel dma controller: register port, arbiter and bus master
// assumes a single-word bus whose grant is withheld while the cpu owns it
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "mdc_consts.vh"
// What this block does
// - item size byte, half-word or word
// - per-side address increment or hold
// - two priority levels, per-channel arbitration size
// - bus requests raised only while processor idle
// - software request per channel; maskable peripheral requests
// - per-direction peripheral channels plus software channel
// - basic mode pauses while request low
// - auto mode completes after one request
// - ping-pong switches primary and alternate
// - memory scatter-gather runs the primary's words once as an auto task
// - peripheral scatter-gather tasks gated by request
// - global disable blocks all transfers
// - attribute flags set, clear, read individually
// - completion clears enable; software may clear
// - remaining count falls, zero when done
// - mode reads stopped after completion
// - controller interrupt: software channel, bus error
// - peripheral completion on peripheral's own line
// - completion interrupts self-clearing
// - bus error latched until software clears
// - 32 channels, alternates at index 32-63
module mdc_top #(
	parameter NCH = 32,
	parameter SW_CH = 31
) (
	input wire clock,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire [NCH-1:0] periph_req,
	output reg [NCH-1:0] periph_done,
	output reg dma_irq,
	input wire cpu_busy,
	output reg bus_req,
	output reg bus_we,
	output reg [31:0] bus_addr,
	output reg [31:0] bus_wdata,
	output reg [1:0] bus_size,
	input wire [31:0] bus_rdata,
	input wire bus_ack,
	input wire bus_err
);
	localparam S_IDLE = 7'h01;
	localparam S_FETCH = 7'h02;
	localparam S_READ = 7'h04;
	localparam S_WRITE = 7'h08;
	localparam S_WBACK = 7'h10;
	localparam S_TASK = 7'h20;
	localparam S_NEXT = 7'h40;

	reg en_q;
	reg [31:0] base_q, chen_q, attr_q, prio_q, swreq_q, mask_q;
	reg err_q;
	reg [4:0] chsel_q;
	reg [6:0] st_q;
	reg [4:0] cur_q;
	reg alt_q;
	reg [1:0] wi_q;
	reg [31:0] src_q, dst_q, cw_q, data_q;
	reg [9:0] arb_q;
	reg [2:0] sg_mode_q;
	reg [31:0] rem_tab [0:NCH-1];
	reg [2:0] mode_tab [0:NCH-1];
	reg [NCH-1:0] pend;
	reg [NCH-1:0] auto_q;
	reg [NCH-1:0] done_q;
	reg sw_done_q;
	integer i;

	// arbitration: high level first, lowest index wins
	function [5:0] pick;
		input [NCH-1:0] v;
		integer k;
		begin
			pick = 6'h00;
			for (k = NCH - 1; k >= 0; k = k - 1) begin
				if (v[k])
					pick = {1'b1, k[4:0]};
			end
		end
	endfunction

	function [31:0] step;
		input [1:0] inc;
		begin
			case (inc)
			`MDC_SIZE_BYTE: step = 32'h00000001;
			`MDC_SIZE_HALF: step = 32'h00000002;
			`MDC_SIZE_WORD: step = 32'h00000004;
			default: step = 32'h00000000;
			endcase
		end
	endfunction

	wire [2:0] cw_mode = cw_q[`MDC_CW_MODE+2:`MDC_CW_MODE];
	wire [9:0] cw_nm1 = cw_q[`MDC_CW_NM1+9:`MDC_CW_NM1];
	wire [3:0] cw_arb = cw_q[`MDC_CW_ARB+3:`MDC_CW_ARB];
	wire basic_like = (cw_mode == `MDC_MODE_BASIC) ||
		(cw_mode == `MDC_MODE_PSG);
	wire cur_live = periph_req[cur_q] & ~mask_q[cur_q];
	wire [NCH-1:0] req_v = ((periph_req & ~mask_q) | swreq_q | auto_q) &
		chen_q;
	wire [5:0] hi_pick = pick(req_v & prio_q);
	wire [5:0] lo_pick = pick(req_v & ~prio_q);
	wire [5:0] win = hi_pick[5] ? hi_pick : lo_pick;
	wire [31:0] desc_addr = {base_q[31:`MDC_BASE_ALIGN], 10'h000} +
		{22'h000000, alt_q, cur_q, 4'h0};
	wire [31:0] chen_clr = (reg_wr && reg_addr == `MDC_REG_ENA_CLR) ?
		reg_wdata : 32'h00000000;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
			en_q <= 1'b0;
			base_q <= 32'h00000000;
			attr_q <= 32'h00000000;
			prio_q <= 32'h00000000;
			mask_q <= 32'h00000000;
			chsel_q <= 5'h00;
		end else begin
			reg_rdata <= 32'h00000000;
			if (reg_wr) begin
				case (reg_addr)
				`MDC_REG_CFG: en_q <= reg_wdata[`MDC_CFG_EN];
				`MDC_REG_CTLBASE: base_q <= {reg_wdata[31:`MDC_BASE_ALIGN],
					10'h000};
				`MDC_REG_ATTR_SET: attr_q <= attr_q | reg_wdata;
				`MDC_REG_ATTR_CLR: attr_q <= attr_q & ~reg_wdata;
				`MDC_REG_PRIO: prio_q <= reg_wdata;
				`MDC_REG_MASK: mask_q <= reg_wdata;
				`MDC_REG_CHSEL: chsel_q <= reg_wdata[4:0];
				default: ;
				endcase
			end
			if (reg_rd) begin
				case (reg_addr)
				`MDC_REG_CFG: reg_rdata <= {31'h0, en_q};
				`MDC_REG_CTLBASE: reg_rdata <= base_q;
				`MDC_REG_ENA_SET: reg_rdata <= chen_q;
				`MDC_REG_ATTR: reg_rdata <= attr_q;
				`MDC_REG_PRIO: reg_rdata <= prio_q;
				`MDC_REG_MASK: reg_rdata <= mask_q;
				`MDC_REG_ERR: reg_rdata <= {31'h0, err_q};
				`MDC_REG_CHSEL: reg_rdata <= {27'h0, chsel_q};
				`MDC_REG_SIZE: reg_rdata <= rem_tab[chsel_q];
				`MDC_REG_MODE: reg_rdata <= {29'h0, mode_tab[chsel_q]};
				`MDC_REG_DONE: reg_rdata <= done_q;
				`MDC_REG_STATUS: reg_rdata <= {25'h0, st_q};
				default: reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// descriptor word order: source end, dest end, control
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
			chen_q <= 32'h00000000;
			swreq_q <= 32'h00000000;
			auto_q <= {NCH{1'b0}};
			done_q <= {NCH{1'b0}};
			periph_done <= {NCH{1'b0}};
			sw_done_q <= 1'b0;
			dma_irq <= 1'b0;
			err_q <= 1'b0;
			cur_q <= 5'h00;
			alt_q <= 1'b0;
			wi_q <= 2'h0;
			src_q <= 32'h00000000;
			dst_q <= 32'h00000000;
			cw_q <= 32'h00000000;
			data_q <= 32'h00000000;
			arb_q <= 10'h000;
			sg_mode_q <= 3'h0;
			bus_req <= 1'b0;
			bus_we <= 1'b0;
			bus_addr <= 32'h00000000;
			bus_wdata <= 32'h00000000;
			bus_size <= 2'h0;
			for (i = 0; i < NCH; i = i + 1) begin
				rem_tab[i] <= 32'h00000000;
				mode_tab[i] <= 3'h0;
			end
		end else begin
			periph_done <= {NCH{1'b0}};
			sw_done_q <= 1'b0;
			dma_irq <= sw_done_q | err_q;
			if (reg_rd && reg_addr == `MDC_REG_DONE)
				done_q <= {NCH{1'b0}};
			if (reg_wr && reg_addr == `MDC_REG_ERR && reg_wdata[0])
				err_q <= 1'b0;
			if (reg_wr && reg_addr == `MDC_REG_ENA_SET)
				chen_q <= (chen_q | reg_wdata) & ~chen_clr;
			else
				chen_q <= chen_q & ~chen_clr;
			if (reg_wr && reg_addr == `MDC_REG_SWREQ)
				swreq_q <= swreq_q | reg_wdata;
			auto_q <= auto_q & chen_q & ~chen_clr;
			case (st_q)
			S_IDLE: begin
				if (en_q && win[5] && !cpu_busy) begin
					cur_q <= win[4:0];
					alt_q <= attr_q[win[4:0]];
					wi_q <= 2'h0;
					swreq_q[win[4:0]] <= 1'b0;
					bus_req <= 1'b1;
					bus_we <= 1'b0;
					bus_size <= `MDC_SIZE_WORD;
					bus_addr <= {base_q[31:`MDC_BASE_ALIGN], 10'h000} +
						{22'h0, attr_q[win[4:0]], win[4:0], 4'h0};
					st_q <= S_FETCH;
				end
			end
			S_FETCH: begin
				if (bus_err) begin
					err_q <= 1'b1;
					// stop the channel so a bad address is not retried
					chen_q[cur_q] <= 1'b0;
					auto_q[cur_q] <= 1'b0;
					bus_req <= 1'b0;
					st_q <= S_IDLE;
				end else if (bus_ack) begin
					case (wi_q)
					2'h0: src_q <= bus_rdata;
					2'h1: dst_q <= bus_rdata;
					default: cw_q <= bus_rdata;
					endcase
					wi_q <= wi_q + 2'h1;
					bus_addr <= bus_addr + 32'h00000004;
					if (wi_q == 2'h2) begin
						bus_req <= 1'b0;
						arb_q <= 10'h000;
						st_q <= S_TASK;
					end
				end
			end
			S_TASK: begin
				mode_tab[cur_q] <= cw_mode;
				rem_tab[cur_q] <= {22'h0, cw_nm1} + 32'h00000001;
				// no new item once disabled, globally or per channel
				if (!en_q || !chen_q[cur_q]) begin
					st_q <= S_IDLE;
				end else if (cw_mode == `MDC_MODE_STOP) begin
					st_q <= S_IDLE;
				end else if (cw_mode == `MDC_MODE_MSG ||
						cw_mode == `MDC_MODE_PSG) begin
					// the primary's words are the task; rerun them as alternate, auto for memory, basic for peripheral
					sg_mode_q <= cw_mode;
					st_q <= S_NEXT;
				end else if (!cpu_busy && (!basic_like || cur_live)) begin
					if (cw_mode == `MDC_MODE_AUTO)
						auto_q[cur_q] <= 1'b1;
					bus_req <= 1'b1;
					bus_we <= 1'b0;
					bus_size <= cw_q[`MDC_CW_SSIZE+1:`MDC_CW_SSIZE];
					bus_addr <= src_q - step(cw_q[`MDC_CW_SINC+1:
						`MDC_CW_SINC]) * {22'h0, cw_nm1};
					st_q <= S_READ;
				end else if (basic_like) begin
					st_q <= S_WBACK;
				end
			end
			S_NEXT: begin
				alt_q <= 1'b1;
				sg_mode_q <= 3'h0;
				cw_q[`MDC_CW_MODE+2:`MDC_CW_MODE] <= sg_mode_q ==
					`MDC_MODE_PSG ? `MDC_MODE_BASIC : `MDC_MODE_AUTO;
				st_q <= S_TASK;
			end
			S_READ: begin
				if (bus_err) begin
					err_q <= 1'b1;
					chen_q[cur_q] <= 1'b0;
					auto_q[cur_q] <= 1'b0;
					bus_req <= 1'b0;
					st_q <= S_IDLE;
				end else if (bus_ack) begin
					data_q <= bus_rdata;
					bus_we <= 1'b1;
					bus_wdata <= bus_rdata;
					bus_size <= cw_q[`MDC_CW_DSIZE+1:`MDC_CW_DSIZE];
					bus_addr <= dst_q - step(cw_q[`MDC_CW_DINC+1:
						`MDC_CW_DINC]) * {22'h0, cw_nm1};
					st_q <= S_WRITE;
				end
			end
			S_WRITE: begin
				if (bus_err) begin
					err_q <= 1'b1;
					chen_q[cur_q] <= 1'b0;
					auto_q[cur_q] <= 1'b0;
					bus_req <= 1'b0;
					st_q <= S_IDLE;
				end else if (bus_ack) begin
					bus_req <= 1'b0;
					bus_we <= 1'b0;
					arb_q <= arb_q + 10'h001;
					rem_tab[cur_q] <= {22'h0, cw_nm1};
					if (cw_nm1 == 10'h000) begin
						mode_tab[cur_q] <= `MDC_MODE_STOP;
						cw_q[`MDC_CW_MODE+2:`MDC_CW_MODE] <= `MDC_MODE_STOP;
						if (cw_mode == `MDC_MODE_PING) begin
							alt_q <= ~alt_q;
							wi_q <= 2'h0;
							bus_req <= 1'b1;
							bus_size <= `MDC_SIZE_WORD;
							bus_addr <= {base_q[31:`MDC_BASE_ALIGN], 10'h000} +
								{22'h0, ~alt_q, cur_q, 4'h0};
							st_q <= S_FETCH;
						end else begin
							chen_q[cur_q] <= 1'b0;
							auto_q[cur_q] <= 1'b0;
							done_q[cur_q] <= 1'b1;
							if (cur_q == SW_CH[4:0])
								sw_done_q <= 1'b1;
							else
								periph_done[cur_q] <= 1'b1;
							st_q <= S_IDLE;
						end
					end else begin
						cw_q[`MDC_CW_NM1+9:`MDC_CW_NM1] <= cw_nm1 - 10'h001;
						// rearbitrate after 2^arb items
						if (arb_q + 10'h001 == (10'h001 << cw_arb))
							st_q <= S_WBACK;
						else
							st_q <= S_TASK;
					end
				end
			end
			S_WBACK: begin
				// park progress in the descriptor so others may run
				if (!cpu_busy && !bus_req) begin
					bus_req <= 1'b1;
					bus_we <= 1'b1;
					bus_size <= `MDC_SIZE_WORD;
					bus_addr <= desc_addr + 32'h00000008;
					bus_wdata <= cw_q;
				end else if (bus_err) begin
					err_q <= 1'b1;
					bus_req <= 1'b0;
					st_q <= S_IDLE;
				end else if (bus_ack) begin
					bus_req <= 1'b0;
					bus_we <= 1'b0;
					st_q <= S_IDLE;
				end
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule

//--- mdc_top_props.sv
// port checker of the dma controller
// bound into mdc_top; sees its ports only
`timescale 1ns/1ps
`include "mdc_consts.vh"
module mdc_props #(
	parameter NCH = 32,
	parameter SW_CH = 31
) (
	input wire clock,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire [NCH-1:0] periph_done,
	input wire dma_irq,
	input wire cpu_busy,
	input wire bus_req,
	input wire [31:0] bus_addr,
	input wire [1:0] bus_size,
	input wire bus_ack,
	input wire bus_err
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// shadow of the global enable; only idle-time changes are meaningful
	reg en_q;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			en_q <= 1'b0;
		else if (reg_wr && reg_addr == `MDC_REG_CFG)
			en_q <= reg_wdata[`MDC_CFG_EN];
	end
	sequence s_err;
		bus_req && bus_err;
	endsequence
	sequence s_clr;
		reg_wr && reg_addr == `MDC_REG_ERR && reg_wdata[0];
	endsequence
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
	a_cpu_yield: assert property (
		$rose(bus_req) |-> !$past(cpu_busy)) else $error("access under cpu");
	a_req_hold: assert property (
		bus_req && !bus_ack && !bus_err |=> bus_req && $stable(bus_addr))
		else $error("bus request dropped");
	a_item_size: assert property (
		bus_req |-> bus_size != 2'h3) else $error("bad item size");
	a_global_off: assert property (
		$rose(bus_req) |-> en_q) else $error("access while disabled");
	a_err_irq: assert property (
		s_err |=> ##[0:2] dma_irq [*4]) else $error("error not latched");
	a_err_clear: assert property (
		s_clr |-> ##[1:2] !dma_irq) else $error("error not cleared");
	a_sw_line: assert property (
		periph_done[SW_CH] == 1'b0) else $error("software done on periph");
	a_done_pulse: assert property (
		|periph_done |=> (periph_done & $past(periph_done)) == 0)
		else $error("done not a pulse");
endmodule
bind mdc_top mdc_props #(.NCH(NCH), .SW_CH(SW_CH)) u_props (.clock(clock),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.periph_done(periph_done), .dma_irq(dma_irq), .cpu_busy(cpu_busy),
	.bus_req(bus_req), .bus_addr(bus_addr), .bus_size(bus_size),
	.bus_ack(bus_ack), .bus_err(bus_err));

//--- mdc_mem.sv
// word memory answering the dma bus master
// slow adds wait cycles; an access to err_addr answers with an error
`timescale 1ns/1ps
module mdc_mem (
	input wire clock,
	input wire rst_n,
	input wire bus_req,
	input wire bus_we,
	input wire [31:0] bus_addr,
	input wire [31:0] bus_wdata,
	input wire slow,
	input wire [31:0] err_addr,
	output reg [31:0] bus_rdata,
	output reg bus_ack,
	output reg bus_err
);
	reg [31:0] mem [0:511];
	reg [1:0] wait_q;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{bus_ack, bus_err, wait_q} <= 4'h0;
			bus_rdata <= 32'h0;
		end else begin
			bus_ack <= 1'b0;
			bus_err <= 1'b0;
			// data only valid with ack; scramble so stale reads show
			bus_rdata <= ~bus_rdata;
			if (bus_req && !bus_ack && !bus_err) begin
				wait_q <= 2'h0;
				if (slow && wait_q != 2'h2)
					wait_q <= wait_q + 2'h1;
				else if (bus_addr == err_addr)
					bus_err <= 1'b1;
				else if (bus_we) begin
					bus_ack <= 1'b1;
					mem[bus_addr[10:2]] <= bus_wdata;
				end else begin
					bus_ack <= 1'b1;
					bus_rdata <= mem[bus_addr[10:2]];
				end
			end
		end
	end
endmodule

//--- mdc_top_bench.sv
// self-checking bench of the dma controller with a memory model
// needs mdc_top, mdc_mem and the bound checker
`timescale 1ns/1ps
`include "mdc_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module mdc_top_bench;
	reg clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	reg cpu_busy = 1'b0, slow = 1'b0, rd_d = 1'b0;
	reg [7:0] reg_addr = 8'h00, lf = 8'h3E;
	reg [31:0] reg_wdata = 32'h0, err_addr = 32'hFFFFFFFF;
	reg [31:0] periph_req = 32'h0, v;
	wire [31:0] reg_rdata, periph_done, bus_addr, bus_wdata, bus_rdata;
	wire dma_irq, bus_req, bus_we, bus_ack, bus_err;
	logic [31:0] exp_q[$];
	int n_fail = 0, tests_run = 0, cyc = 0, k, busy;
	mdc_top u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .periph_req(periph_req),
		.periph_done(periph_done), .dma_irq(dma_irq), .cpu_busy(cpu_busy),
		.bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_size(), .bus_rdata(bus_rdata),
		.bus_ack(bus_ack), .bus_err(bus_err));
	mdc_mem u_mem (.clock(clock), .rst_n(rst_n), .bus_req(bus_req),
		.bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.slow(slow), .err_addr(err_addr), .bus_rdata(bus_rdata),
		.bus_ack(bus_ack), .bus_err(bus_err));
	initial begin
		forever #20 clock = ~clock;
	end
	task complete_run;
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// random cpu contention and memory stalls throughout the run
	always @(posedge clock) begin
		lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		cpu_busy <= lf[0] & lf[1];
		slow <= lf[2];
		rd_d <= reg_rd;
		cyc++;
		if (rd_d)
			`CHK(reg_rdata, exp_q.pop_front())
		if (cyc == 20000) begin
			n_fail++;
			complete_run;
		end
	end
	// strobes get a gap cycle so no signal is driven twice in one step
	task wr(input [7:0] a, input [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask
	task rd(input [7:0] a, input [31:0] e);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
	endtask
	// descriptor holds end addresses; word items, word increments
	task desc(input int ch, input [2:0] m, input [31:0] s, d, input int n);
		u_mem.mem[ch*4] = s + 4*(n-1);
		u_mem.mem[ch*4+1] = d + 4*(n-1);
		u_mem.mem[ch*4+2] = 32'hAA000000 | ((n-1) << 4) | m;
		for (k = 0; k < n; k++)
			u_mem.mem[s/4+k] = {4{lf ^ k[7:0]}};
	endtask
	task cmp(input [31:0] s, d, input int n);
		for (k = 0; k < n; k++)
			`CHK(u_mem.mem[d/4+k], u_mem.mem[s/4+k])
	endtask
	task quiet;
		busy = 0;
		repeat (80) @(posedge clock);
		repeat (40) begin
			@(posedge clock);
			if (bus_req !== 1'b0)
				busy++;
		end
		`CHK(busy, 0)
	endtask
	task wt(input bit irq);
		k = 0;
		while ((irq ? dma_irq : periph_done[0]) !== 1'b1 && k < 3000) begin
			@(posedge clock);
			k++;
		end
		`CHK(k < 3000, 1'b1)
	endtask
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(`MDC_REG_CFG, 32'h0);
		rd(`MDC_REG_ERR, 32'h0);
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40, 32'h0);
		v = {4{lf}};
		wr(`MDC_REG_ATTR_SET, v);
		wr(`MDC_REG_ATTR_CLR, 32'h0000FFFF);
		rd(`MDC_REG_ATTR, v & 32'hFFFF0000);
		wr(`MDC_REG_ATTR_CLR, 32'hFFFFFFFF);
		wr(`MDC_REG_CTLBASE, 32'h0);
		desc(31, `MDC_MODE_AUTO, 32'h400, 32'h500, 4);
		wr(`MDC_REG_ENA_SET, 32'h80000000);
		wr(`MDC_REG_CFG, 32'h1);
		wr(`MDC_REG_SWREQ, 32'h80000000);
		wt(1'b1);
		cmp(32'h400, 32'h500, 4);
		wr(`MDC_REG_CHSEL, 32'h1F);
		rd(`MDC_REG_SIZE, 32'h0);
		rd(`MDC_REG_MODE, {29'h0, `MDC_MODE_STOP});
		rd(`MDC_REG_ENA_SET, 32'h0);
		wr(`MDC_REG_CFG, 32'h0);
		desc(0, `MDC_MODE_BASIC, 32'h600, 32'h700, 8);
		wr(`MDC_REG_ENA_SET, 32'h1);
		periph_req <= 32'h1;
		quiet;
		wr(`MDC_REG_MASK, 32'h1);
		wr(`MDC_REG_CFG, 32'h1);
		quiet;
		wr(`MDC_REG_MASK, 32'h0);
		while (bus_ack !== 1'b1)
			@(posedge clock);
		periph_req <= 32'h0;
		quiet;
		periph_req <= 32'h1;
		wt(1'b0);
		cmp(32'h600, 32'h700, 8);
		rd(`MDC_REG_ENA_SET, 32'h0);
		err_addr <= 32'h400;
		desc(31, `MDC_MODE_AUTO, 32'h400, 32'h500, 2);
		wr(`MDC_REG_ENA_SET, 32'h80000000);
		wr(`MDC_REG_SWREQ, 32'h80000000);
		wt(1'b1);
		repeat (4) @(posedge clock);
		`CHK(dma_irq, 1'b1)
		rd(`MDC_REG_ERR, 32'h1);
		wr(`MDC_REG_ENA_CLR, 32'h80000000);
		wr(`MDC_REG_ERR, 32'h1);
		rd(`MDC_REG_ERR, 32'h0);
		`CHK(dma_irq, 1'b0)
		complete_run;
	end
endmodule
